// ---- rtl/tra_regs.sv ----
// tra_regs: per-channel register sets reached through the control/status
// byte of the process image, with code-word protection and output scaling.
// Assumes the coupler presents a new output image with img_stb on ref_clk.
//
// Operation
// - each channel owns 64 word registers, readable and partly writable
// - areas: process 0-7, type 8-15, factory 16-31, user 32-47, extended 48-63
// - every channel keeps its own independent copy of all writable registers; fixed type values are shared
// - type registers hold fixed values except alignment at 15; writes to the others change nothing
// - first type register gives type number, next gives version as ASCII
// - shift register count/length and logical channel count are reported
// - minimum transfer length byte; its top bit drops the status byte
// - data-type code: 0 none, 1/3/5 arrays, plus 0x10 variable length
// - alignment bits sit in a volatile writable register
// - factory parameters change only while the code word is present
// - user parameters are write-protected unless the code word is set
// - 0x1235 unlocks, anything else locks; read gives key or zero
// - control bit 7 set turns the two data bytes into register access
// - control bit 6 picks read (value returned) or write of the data
// - control bits 0 to 5 select one of the 64 registers
// - host sees a write finished when status equals its control byte with bit 6 cleared
// - status byte comes first, register value in the two bytes after
// - write acknowledge is bit 7 plus address with write bit cleared
// - a process register shows the 12-bit code sent to the converter
// - trim low bytes load into 8-bit pots after reset and each write
// - factory line offset is signed 16 bit, default zero
// - feature bit 0 enables user scaling, bit 1 factory scaling
// - factory gain is unsigned with 8 fraction bits, 0x0100 is unity
`timescale 1ns/1ps
`default_nettype none

module tra_regs
  import tra_pkg::*;
#(
  parameter int          NCH        = 2,
  parameter logic [15:0] TYPE_ID    = 16'h0ABC,  // arbitrary value
  parameter logic [15:0] FW_TEXT    = 16'h3141,  // arbitrary value
  parameter logic [15:0] SHIFT_LEN  = 16'h0220,
  parameter logic [15:0] CH_COUNT   = 16'h0002,
  parameter logic [15:0] MIN_LEN    = 16'h1818
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  // process image from the coupler
  input  wire logic                     img_stb,
  input  wire tra_out_img_s [NCH-1:0]   out_img,
  // process image back to the coupler
  output var tra_in_img_s [NCH-1:0]     in_img,
  // converter and trim pots
  output logic [NCH-1:0][11:0]          dac_code,
  output logic [NCH-1:0][7:0]           offset_pot,
  output logic [NCH-1:0][7:0]           gain_pot,
  output logic [NCH-1:0]                pot_load
);

  // elaboration check: the coupler image holds at most this many sets
  if (NCH < 1 || NCH > 8) begin : g_bad_nch
    $error("tra_regs: NCH must be 1 to 8");
  end

  typedef struct packed {
    logic                 boot;
    tra_ch_s [NCH-1:0]    ch;
  } tra_st_s;

  tra_st_s st_q;
  tra_st_s st_d;

  // one straight line y = b + a*x/256, saturated to signed 16 bit
  function automatic logic [15:0] line_fn(input logic [15:0] x,
                                          input logic [15:0] b,
                                          input logic [15:0] a,
                                          input logic        a_signed);
    logic signed [33:0] prod;
    logic signed [33:0] sum;
    logic signed [16:0] a_ext;
    a_ext = a_signed ? {a[15], a} : {1'b0, a};
    prod  = 34'(signed'(x)) * 34'(a_ext);
    sum   = (prod >>> 8) + 34'(signed'(b));
    if (sum > 34'sd32767) line_fn = 16'h7FFF;
    else if (sum < -34'sd32768) line_fn = 16'h8000;
    else line_fn = sum[15:0];
  endfunction

  // register read mux for one channel set
  function automatic logic [15:0] read_fn(input tra_ch_s c,
                                          input logic [5:0] a);
    unique case (a)
      TRA_RAW_CODE:  read_fn = {4'h0, c.dac};
      TRA_TYPE_ID:   read_fn = TYPE_ID;
      TRA_FW_TEXT:   read_fn = FW_TEXT;
      TRA_SHIFT_LEN: read_fn = SHIFT_LEN;
      TRA_CH_COUNT:  read_fn = CH_COUNT;
      TRA_MIN_LEN:   read_fn = MIN_LEN;
      TRA_DATA_TYPE: read_fn = {8'h00, TRA_DT_WORDS};
      TRA_ALIGN:     read_fn = c.align;
      TRA_HW_REV:    read_fn = c.hw_rev;
      TRA_OFF_POT:   read_fn = c.off_pot;
      TRA_GAIN_POT:  read_fn = c.gain_pot;
      TRA_FAC_OFF:   read_fn = c.fac_off;
      TRA_FAC_GAIN:  read_fn = c.fac_gain;
      TRA_KEY:       read_fn = (c.key == TRA_UNLOCK) ? c.key : 16'h0000;
      TRA_FEATURES:  read_fn = c.features;
      TRA_USR_OFF:   read_fn = c.usr_off;
      TRA_USR_GAIN:  read_fn = c.usr_gain;
      default:       read_fn = 16'h0000;       // unused locations read zero
    endcase
  endfunction

  // next-state logic; each channel touches only its own slice
  always_comb begin
    logic [5:0]  adr;
    logic        unl;
    logic [15:0] x;
    logic [15:0] y;
    tra_ch_s     c;
    adr  = 6'h00;
    unl  = 1'b0;
    x    = 16'h0000;
    y    = 16'h0000;
    c    = '0;
    st_d = st_q;
    st_d.boot = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      c   = st_q.ch[i];
      adr = out_img[i].ctrl[5:0];
      unl = (c.key == TRA_UNLOCK);
      c.pot_load = st_q.boot;
      if (img_stb) begin
        if (out_img[i].ctrl[TRA_REG_BIT]) begin
          if (out_img[i].ctrl[TRA_WR_BIT]) begin
            // protected or read-only targets fall through untouched
            unique case (adr)
              TRA_ALIGN:    c.align = out_img[i].data;
              TRA_KEY:      c.key   = out_img[i].data;
              default: begin
                if (unl && adr >= TRA_FAC_FIRST && adr <= TRA_USR_LAST) begin
                  unique case (adr)
                    TRA_HW_REV:   c.hw_rev   = out_img[i].data;
                    TRA_OFF_POT: begin
                      c.off_pot  = out_img[i].data;
                      c.pot_load = 1'b1;
                    end
                    TRA_GAIN_POT: begin
                      c.gain_pot = out_img[i].data;
                      c.pot_load = 1'b1;
                    end
                    TRA_FAC_OFF:  c.fac_off  = out_img[i].data;
                    TRA_FAC_GAIN: c.fac_gain = out_img[i].data;
                    TRA_FEATURES: c.features = out_img[i].data;
                    TRA_USR_OFF:  c.usr_off  = out_img[i].data;
                    TRA_USR_GAIN: c.usr_gain = out_img[i].data;
                    default: ;
                  endcase
                end
              end
            endcase
            // acknowledge even when nothing was stored
            c.in_img.status = {1'b1, 1'b0, adr};
            c.in_img.data   = 16'h0000;
          end else begin
            // read leaves every register as it was
            c.in_img.status = out_img[i].ctrl;
            c.in_img.data   = read_fn(st_q.ch[i], adr);
          end
        end else begin
          // process data mode: run the enabled straight lines
          x = out_img[i].data;
          y = x;
          if (c.features[TRA_FEAT_FAC])
            y = line_fn(y, c.fac_off, c.fac_gain, 1'b0);
          if (c.features[TRA_FEAT_USR])
            y = line_fn(y, c.usr_off, c.usr_gain, 1'b1);
          // negative clips to zero; full scale 0x7FFF maps to 0xFFF
          c.dac = y[15] ? 12'h000 : y[14:3];
          c.in_img.status = 8'h00;
          c.in_img.data   = 16'h0000;
        end
      end
      st_d.ch[i] = c;
    end
  end

  // state register; async reset loads constants only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q.boot <= 1'b1;
      for (int i = 0; i < NCH; i++) begin
        st_q.ch[i].align    <= TRA_RST_ZERO;
        st_q.ch[i].hw_rev   <= TRA_RST_ZERO;
        st_q.ch[i].off_pot  <= TRA_RST_POT;
        st_q.ch[i].gain_pot <= TRA_RST_POT;
        st_q.ch[i].fac_off  <= TRA_RST_ZERO;
        st_q.ch[i].fac_gain <= TRA_RST_UNITY;
        st_q.ch[i].key      <= TRA_RST_ZERO;
        st_q.ch[i].features <= TRA_RST_FEAT;
        st_q.ch[i].usr_off  <= TRA_RST_ZERO;
        st_q.ch[i].usr_gain <= TRA_RST_UNITY;
        st_q.ch[i].dac      <= 12'h000;
        st_q.ch[i].pot_load <= 1'b0;
        st_q.ch[i].in_img   <= '0;
      end
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      in_img[i]     = st_q.ch[i].in_img;
      dac_code[i]   = st_q.ch[i].dac;
      offset_pot[i] = st_q.ch[i].off_pot[7:0];
      gain_pot[i]   = st_q.ch[i].gain_pot[7:0];
      pot_load[i]   = st_q.ch[i].pot_load;
    end
  end

endmodule // tra_regs

`default_nettype wire

// ---- shared/tra_pkg.sv ----
// tra_pkg: constants and carriers for the terminal register access block.
// Assumes one clock domain; the coupler image logic runs on the same clock.
package tra_pkg;

  // register map (word index inside one channel set)
  localparam logic [5:0] TRA_RAW_CODE  = 6'h05;
  localparam logic [5:0] TRA_TYPE_ID   = 6'h08;
  localparam logic [5:0] TRA_FW_TEXT   = 6'h09;
  localparam logic [5:0] TRA_SHIFT_LEN = 6'h0A;
  localparam logic [5:0] TRA_CH_COUNT  = 6'h0B;
  localparam logic [5:0] TRA_MIN_LEN   = 6'h0C;
  localparam logic [5:0] TRA_DATA_TYPE = 6'h0D;
  localparam logic [5:0] TRA_ALIGN     = 6'h0F;
  localparam logic [5:0] TRA_HW_REV    = 6'h10;
  localparam logic [5:0] TRA_OFF_POT   = 6'h11;
  localparam logic [5:0] TRA_GAIN_POT  = 6'h12;
  localparam logic [5:0] TRA_FAC_OFF   = 6'h13;
  localparam logic [5:0] TRA_FAC_GAIN  = 6'h14;
  localparam logic [5:0] TRA_KEY       = 6'h1F;
  localparam logic [5:0] TRA_FEATURES  = 6'h20;
  localparam logic [5:0] TRA_USR_OFF   = 6'h21;
  localparam logic [5:0] TRA_USR_GAIN  = 6'h22;

  // area bounds
  localparam logic [5:0] TRA_FAC_FIRST = 6'h10;
  localparam logic [5:0] TRA_FAC_LAST  = 6'h1E;
  localparam logic [5:0] TRA_USR_LAST  = 6'h2F;

  // control byte fields
  localparam int TRA_REG_BIT = 7;
  localparam int TRA_WR_BIT  = 6;

  // feature bits
  localparam int TRA_FEAT_USR = 0;
  localparam int TRA_FEAT_FAC = 1;

  // key, reset and fixed read values
  localparam logic [15:0] TRA_UNLOCK    = 16'h1235;
  localparam logic [15:0] TRA_RST_FEAT  = 16'h0006;
  localparam logic [15:0] TRA_RST_ZERO  = 16'h0000;
  localparam logic [15:0] TRA_RST_UNITY = 16'h0100;
  localparam logic [15:0] TRA_RST_POT   = 16'h0080;
  localparam logic [7:0]  TRA_DT_WORDS  = 8'h03;

  // one channel's view of the output image (controller to terminal)
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] data;
  } tra_out_img_s;

  // one channel's view of the input image (terminal to controller)
  typedef struct packed {
    logic [7:0]  status;
    logic [15:0] data;
  } tra_in_img_s;

  // writable and live state of one channel set
  typedef struct packed {
    logic [15:0] align;
    logic [15:0] hw_rev;
    logic [15:0] off_pot;
    logic [15:0] gain_pot;
    logic [15:0] fac_off;
    logic [15:0] fac_gain;
    logic [15:0] key;
    logic [15:0] features;
    logic [15:0] usr_off;
    logic [15:0] usr_gain;
    logic [11:0] dac;
    logic        pot_load;
    tra_in_img_s in_img;
  } tra_ch_s;

endpackage

// ---- bench/tra_regs_sva.sv ----
// tra_regs_chk: port checks on channel 0 of the register block, plus an image-hold check on all channels.
// Assumes bind onto tra_regs; one ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module tra_regs_chk
  import tra_pkg::*;
#(parameter int NCH = 2) (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   resetn,
  // process images
  input wire logic                   img_stb,
  input wire tra_out_img_s [NCH-1:0] out_img,
  input wire tra_in_img_s [NCH-1:0]  in_img,
  // analog side
  input wire logic [NCH-1:0][11:0]   dac_code,
  input wire logic [NCH-1:0][7:0]    offset_pot,
  input wire logic [NCH-1:0][7:0]    gain_pot,
  input wire logic [NCH-1:0]         pot_load
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] c;
  // channel 0 control byte only, to keep the checker small
  assign c = out_img[0].ctrl;
  chk_proc_status: assert property (img_stb && !c[7] |=> in_img[0].status == 8'h00)
    else $error("process status not zero");
  chk_read_echo: assert property (img_stb && c[7:6] == 2'b10 |=> in_img[0].status == $past(c))
    else $error("read status not echoed");
  chk_write_ack: assert property (img_stb && c[7:6] == 2'b11
    |=> in_img[0].status == {2'b10, $past(c[5:0])})
    else $error("write ack wrong");
  chk_ack_data: assert property (img_stb && c[7:6] == 2'b11 |=> in_img[0].data == 16'h0000)
    else $error("ack data not zero");
  chk_type_code: assert property (img_stb && c == 8'h8D |=> in_img[0].data == 16'h0003)
    else $error("data type wrong");
  chk_ext_zero: assert property (img_stb && c[7:6] == 2'b10 && c[5:4] == 2'b11
    |=> in_img[0].data == 16'h0000)
    else $error("extended area not zero");
  chk_pot_strobe: assert property ($changed(offset_pot[0]) || $changed(gain_pot[0])
    |-> pot_load[0])
    else $error("pot changed without load");
  chk_pot_pulse: assert property (pot_load[0] && !img_stb |=> !pot_load[0])
    else $error("pot load longer than one cycle");
  chk_image_hold: assert property (!img_stb |=> $stable(in_img))
    else $error("input image moved without strobe");
  cov_read: cover property (img_stb && c[7:6] == 2'b10);
  cov_write: cover property (img_stb && c[7:6] == 2'b11);
  cov_proc: cover property (img_stb && !c[7]);
endmodule // tra_regs_chk
bind tra_regs tra_regs_chk #(.NCH(NCH)) tra_regs_chk_i (.ref_clk(ref_clk), .resetn(resetn),
  .img_stb(img_stb), .out_img(out_img), .in_img(in_img), .dac_code(dac_code),
  .offset_pot(offset_pot), .gain_pot(gain_pot), .pot_load(pot_load));
`default_nettype wire

// ---- bench/tra_coupler.sv ----
// tra_coupler: bus coupler model relaying one register request per go.
// Assumes the bench holds ch and req steady until busy falls.
`timescale 1ns/1ps
`default_nettype none
module tra_coupler
  import tra_pkg::*;
#(parameter int NCH = 2) (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   resetn,
  // request from the bench
  input wire logic                   go,
  input wire logic                   ch,
  input wire tra_out_img_s           req,
  output logic                       busy,
  // images
  input wire tra_in_img_s [NCH-1:0]  in_img,
  output logic                       img_stb,
  output tra_out_img_s [NCH-1:0]     out_img
);
  logic [1:0] n;
  logic       match;
  // write ack drops the direction bit, process mode answers zero
  assign match = in_img[ch].status == (req.ctrl[7] ? (req.ctrl & 8'hBF) : 8'h00);
  // image held and restrobed until matched; idle image toggles as junk
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      n <= 2'd0;
      img_stb <= 1'b0;
      out_img <= '0;
    end else if (go) begin
      busy <= 1'b1;
      n <= 2'd0;
      img_stb <= 1'b1;
      for (int i = 0; i < NCH; i++) out_img[i] <= (i == int'(ch)) ? req : '0;
    end else if (busy) begin
      n <= (n == 2'd2) ? n : n + 2'd1;
      img_stb <= !match;
      if (n == 2'd2 && match) busy <= 1'b0;
    end else begin
      img_stb <= 1'b0;
      out_img <= ~out_img;
    end
  end
endmodule // tra_coupler
`default_nettype wire

// ---- bench/test_terminal_register_access.sv ----
// test_terminal_register_access: register reads and writes on both channels.
// Assumes tra_regs with two channels and the coupler model beside it.
`timescale 1ns/1ps
`default_nettype none
module test_terminal_register_access;
  import tra_pkg::*;
  localparam logic [15:0] TID = 16'h0123; // arbitrary value
  localparam logic [15:0] FWT = 16'h3241;
  localparam logic [15:0] MLN = 16'h8018;
  logic                ref_clk = 1'b0;
  logic                resetn = 1'b0;
  logic                go = 1'b0;
  logic                ch = 1'b0;
  tra_out_img_s        req = '0;
  logic                busy, img_stb;
  tra_out_img_s [1:0]  out_img;
  tra_in_img_s [1:0]   in_img;
  tra_in_img_s         rsp;
  logic [1:0][11:0]    dac_code;
  logic [1:0][7:0]     offset_pot, gain_pot;
  logic [1:0]          pot_load;
  int                  err_total = 0;
  int                  compares = 0;
  logic [5:0]          ta[7] = '{6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h3F};
  logic [15:0]         tv[7] = '{TID, FWT, 16'h0220, 16'h0002, MLN, 16'h0003, 16'h0000};

  tra_regs #(.NCH(2), .TYPE_ID(TID), .FW_TEXT(FWT), .SHIFT_LEN(16'h0220),
    .CH_COUNT(16'h0002), .MIN_LEN(MLN)) tra_regs_i (.ref_clk(ref_clk), .resetn(resetn),
    .img_stb(img_stb), .out_img(out_img), .in_img(in_img), .dac_code(dac_code),
    .offset_pot(offset_pot), .gain_pot(gain_pot), .pot_load(pot_load));
  tra_coupler #(.NCH(2)) tra_coupler_i (.ref_clk(ref_clk), .resetn(resetn), .go(go),
    .ch(ch), .req(req), .busy(busy), .in_img(in_img), .img_stb(img_stb), .out_img(out_img));

  // clock
  initial forever #20 ref_clk = ~ref_clk;

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one transaction through the coupler, bounded wait for the match
  task automatic xfer(input logic c, input logic [7:0] ct, input logic [15:0] d);
    int k;
    @(posedge ref_clk);
    #1 ch = c;
    req = '{ctrl: ct, data: d};
    go = 1'b1;
    @(posedge ref_clk);
    #1 go = 1'b0;
    // look one step after each edge so busy has settled
    for (k = 0; busy && k < 50; k++) begin
      @(posedge ref_clk);
      #1;
    end
    cmp("handshake", 16'h0000, {15'h0, busy});
    rsp = in_img[c];
  endtask

  task automatic wr(input logic c, input logic [5:0] a, input logic [15:0] d);
    xfer(c, {2'b11, a}, d);
    cmp("ack", {8'h00, 2'b10, a}, {8'h00, rsp.status});
    cmp("ack data", 16'h0000, rsp.data);
  endtask

  task automatic rd(input logic c, input logic [5:0] a, input logic [15:0] e);
    xfer(c, {2'b10, a}, 16'h0000);
    cmp("status", {8'h00, 2'b10, a}, {8'h00, rsp.status});
    cmp("reg", e, rsp.data);
  endtask

  // watchdog
  initial begin
    #80000;
    err_total++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    cmp("pot reset", 16'h0080, {8'h00, offset_pot[0]});
    #1 resetn = 1'b1;
    @(posedge ref_clk);
    #1 cmp("pot load", 16'h0003, {14'h0, pot_load});
    for (int i = 0; i < 7; i++) rd(1'b0, ta[i], tv[i]);
    wr(1'b0, 6'h08, 16'hFFFF);
    rd(1'b0, 6'h08, TID);
    wr(1'b0, 6'h13, 16'h1234);
    rd(1'b0, 6'h13, 16'h0000);
    wr(1'b0, 6'h21, 16'h0055);
    rd(1'b0, 6'h21, 16'h0000);
    wr(1'b1, 6'h1F, TRA_UNLOCK);
    rd(1'b1, 6'h1F, TRA_UNLOCK);
    rd(1'b0, 6'h1F, 16'h0000);
    wr(1'b1, 6'h11, 16'hAB42);
    cmp("offset pot", 16'h0042, {8'h00, offset_pot[1]});
    cmp("other pot", 16'h0080, {8'h00, offset_pot[0]});
    wr(1'b1, 6'h13, 16'h0010);
    rd(1'b1, 6'h13, 16'h0010);
    wr(1'b1, 6'h12, 16'h0137);
    cmp("gain pot", 16'h0037, {8'h00, gain_pot[1]});
    xfer(1'b1, 8'h00, 16'h4000);
    cmp("dac scaled", 16'h0802, {4'h0, dac_code[1]});
    wr(1'b1, 6'h21, 16'h0055);
    rd(1'b1, 6'h21, 16'h0055);
    wr(1'b1, 6'h1F, 16'h1234);
    rd(1'b1, 6'h1F, 16'h0000);
    wr(1'b1, 6'h13, 16'h0777);
    rd(1'b1, 6'h13, 16'h0010);
    wr(1'b0, 6'h0F, 16'h00A5);
    rd(1'b0, 6'h0F, 16'h00A5);
    xfer(1'b0, 8'h00, 16'h4000);
    cmp("proc status", 16'h0000, {8'h00, rsp.status});
    cmp("dac", 16'h0800, {4'h0, dac_code[0]});
    rd(1'b0, 6'h05, 16'h0800);
    summarize();
  end
endmodule // test_terminal_register_access
`default_nettype wire
